// >>> include/static_memory_io_controller_regs.vh
// register offsets, fields, reset values and trap codes of the static memory / io controller
// assumes a 32-bit aligned AXI4-Lite register map and a 32-bit internal address
`ifndef STATIC_MEMORY_IO_CONTROLLER_REGS_VH
`define STATIC_MEMORY_IO_CONTROLLER_REGS_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ROMIO_CFG_OFF 4'h0
`define RAM_CFG_OFF   4'h4
`define ECC_CFG_OFF   4'h8
`define STATUS_OFF    4'hC

// ---------------------------------------------------------------
// rom / io configuration fields
// ---------------------------------------------------------------
`define F_ROM_WIDTH   0
`define F_IO_EN       1
`define F_IO_WIDTH    2
`define F_IO_WAIT     3
`define F_IO_RDY      7
`define F_ASYNC_RDY   8
`define F_ROM_RWAIT   9
`define F_ROM_WWAIT   13
`define F_ROM_RDY     17
`define ROMIO_CFG_RST 18'h1FE00

// ---------------------------------------------------------------
// ram configuration fields
// ---------------------------------------------------------------
`define F_RAM_EN      0
`define F_RAM_WIDTH   1
`define F_RAM_BS      2
`define F_RAM_RWAIT   6
`define F_RAM_WWAIT   8
`define F_RAM_RMW     10
`define F_RAM_RDY     11
`define F_DRAM_EN     12
`define RAM_CFG_RST   13'h0000

// ---------------------------------------------------------------
// ecc configuration fields
// ---------------------------------------------------------------
`define F_ROM_ECC     0
`define F_RAM_ECC     1
`define ECC_CFG_RST   2'h0

// ---------------------------------------------------------------
// trap codes and fixed windows
// ---------------------------------------------------------------
`define TRAP_FETCH    8'h01
`define TRAP_LOAD     8'h09
`define TRAP_STORE    8'h2B
`define BANK_MIN_LOG2 13
`define BANK4_TOP     4'h6

`endif

// >>> core/static_memory_io_controller.v
// static memory and io access engine with AXI4-Lite configuration registers
// assumes one clock; memory pins are asynchronous and are synchronised here
`timescale 1ns/1ps
`include "static_memory_io_controller_regs.vh"

module static_memory_io_controller #(
	parameter BANK_SIZE_W = 4
) (
	input  wire        clk,
	input  wire        sys_rst,
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [31:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        req_valid,
	output wire        req_ready,
	input  wire [31:0] req_addr,
	input  wire        req_write,
	input  wire        req_fetch,
	input  wire [3:0]  req_strb,
	input  wire [31:0] req_wdata,
	input  wire [7:0]  req_wcheck,
	output reg         resp_valid,
	output reg  [31:0] resp_rdata,
	output reg  [7:0]  resp_check,
	output reg         resp_trap,
	output reg  [7:0]  resp_trap_code,
	output wire [27:0] mem_addr,
	output wire [31:0] mem_data_out,
	output wire        mem_data_oe_n,
	input  wire [31:0] mem_data_in,
	output wire [7:0]  check_bits_bus_out,
	output wire        check_bits_bus_oe_n,
	input  wire [7:0]  check_bits_bus_in,
	output wire        read_strobe,
	output wire        output_enable_n,
	output wire        write_n,
	output wire [1:0]  rom_select_n,
	output wire        io_area_select_n,
	output wire        io_strobe_select_n,
	output wire [4:0]  ram_bank_select_n,
	output wire [3:0]  ram_output_enable_n,
	output wire [3:0]  ram_lane_write_n,
	input  wire        external_ready_n,
	output wire        dram_ecc_enable
);

	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	reg  [17:0] romio_cfg_reg;
	reg  [12:0] ram_cfg_reg;
	reg  [1:0]  ecc_cfg_reg;
	reg         aw_hold_reg;
	reg  [3:0]  aw_addr_reg;
	reg         aw_bad_reg;
	reg         w_hold_reg;
	reg  [31:0] w_data_reg;
	reg  [3:0]  w_strb_reg;
	reg  [7:0]  last_trap_reg;
	wire [31:0] wmask;
	wire        do_write;

	wire        rom_byte   = romio_cfg_reg[`F_ROM_WIDTH];
	wire        io_en      = romio_cfg_reg[`F_IO_EN];
	wire        io_byte    = romio_cfg_reg[`F_IO_WIDTH];
	wire [3:0]  io_wait    = romio_cfg_reg[`F_IO_WAIT +: 4];
	wire        io_rdy     = romio_cfg_reg[`F_IO_RDY];
	wire        async_rdy  = romio_cfg_reg[`F_ASYNC_RDY];
	wire [3:0]  rom_rwait  = romio_cfg_reg[`F_ROM_RWAIT +: 4];
	wire [3:0]  rom_wwait  = romio_cfg_reg[`F_ROM_WWAIT +: 4];
	wire        rom_rdy    = romio_cfg_reg[`F_ROM_RDY];
	wire        ram_en     = ram_cfg_reg[`F_RAM_EN];
	wire        ram_byte   = ram_cfg_reg[`F_RAM_WIDTH];
	wire [3:0]  ram_bs     = ram_cfg_reg[`F_RAM_BS +: BANK_SIZE_W];
	wire [1:0]  ram_rwait  = ram_cfg_reg[`F_RAM_RWAIT +: 2];
	wire [1:0]  ram_wwait  = ram_cfg_reg[`F_RAM_WWAIT +: 2];
	wire        ram_rmw    = ram_cfg_reg[`F_RAM_RMW];
	wire        ram_rdy    = ram_cfg_reg[`F_RAM_RDY];
	wire        dram_en    = ram_cfg_reg[`F_DRAM_EN];
	wire        rom_ecc    = ecc_cfg_reg[`F_ROM_ECC];
	wire        ram_ecc    = ecc_cfg_reg[`F_RAM_ECC];

	assign dram_ecc_enable = ram_ecc;
	assign s_axi_awready = !aw_hold_reg;
	assign s_axi_wready  = !w_hold_reg;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
	assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
		{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_hold_reg <= 1'b0;
			aw_addr_reg <= 4'h0;
			aw_bad_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			romio_cfg_reg <= `ROMIO_CFG_RST;
			ram_cfg_reg <= `RAM_CFG_RST;
			ecc_cfg_reg <= `ECC_CFG_RST;
		end else begin
			if (s_axi_awvalid && !aw_hold_reg) begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr[3:0];
				aw_bad_reg <= (s_axi_awaddr[31:4] != 28'h0000000);
			end
			if (s_axi_wvalid && !w_hold_reg) begin
				w_hold_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (do_write) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'h2;
				if (!aw_bad_reg) begin
					case (aw_addr_reg)
					`ROMIO_CFG_OFF: begin
						romio_cfg_reg <= (romio_cfg_reg & ~wmask[17:0])
							| (w_data_reg[17:0] & wmask[17:0]);
						s_axi_bresp <= 2'h0;
					end
					`RAM_CFG_OFF: begin
						ram_cfg_reg <= (ram_cfg_reg & ~wmask[12:0])
							| (w_data_reg[12:0] & wmask[12:0]);
						s_axi_bresp <= 2'h0;
					end
					`ECC_CFG_OFF: begin
						ecc_cfg_reg <= (ecc_cfg_reg & ~wmask[1:0])
							| (w_data_reg[1:0] & wmask[1:0]);
						s_axi_bresp <= 2'h0;
					end
					default: s_axi_bresp <= 2'h2;
					endcase
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// access engine state
	// ---------------------------------------------------------------
	localparam S_IDLE = 3'h0;
	localparam S_LEAD = 3'h1;
	localparam S_DATA = 3'h2;
	localparam S_TAIL = 3'h3;
	localparam S_RESP = 3'h4;

	reg  [2:0]  state_reg;
	reg  [31:0] addr_reg;
	reg  [31:0] wdata_reg;
	reg  [7:0]  wcheck_reg;
	reg  [3:0]  strb_reg;
	reg         wr_reg;
	reg         rmw_reg;
	reg         is_rom_reg;
	reg         is_io_reg;
	reg  [4:0]  ram_sel_reg;
	reg         byte_reg;
	reg         burst_reg;
	reg         ecc_reg;
	reg         lead_reg;
	reg  [2:0]  beat_reg;
	reg  [2:0]  last_beat_reg;
	reg  [4:0]  cnt_reg;
	reg         tail_reg;
	reg  [31:0] rdata_reg;
	reg  [7:0]  rcheck_reg;
	reg  [31:0] data_s1;
	reg  [31:0] data_s2;
	reg  [7:0]  check_s1;
	reg  [7:0]  check_s2;
	reg         rdy_s1;
	reg         rdy_s2;
	reg         rdy_s3;

	// ---------------------------------------------------------------
	// request decode
	// ---------------------------------------------------------------
	wire        a_rom  = (req_addr[31:29] == 3'h0);
	wire        a_io   = (req_addr[31:29] == 3'h1);
	wire        a_ram  = (req_addr[31:30] == 2'h1);
	wire        a_byte = a_rom ? rom_byte : (a_io ? io_byte : (a_ram && ram_byte));
	wire        a_burst = a_byte && !a_io;
	wire        a_ecc  = a_io ? 1'b0 : (a_rom ? rom_ecc : (a_ram && ram_ecc));
	wire        a_trap = a_io && !io_en;
	wire [29:0] bank_idx = req_addr[29:0] >> (`BANK_MIN_LOG2 + ram_bs);
	wire        hit_dram = dram_en && req_addr[29];
	wire        hit_b4 = (req_addr[31:28] == `BANK4_TOP) && !dram_en;
	wire        a_rmw = a_ram && !a_byte && req_write && (req_strb != 4'hF)
		&& (ram_rmw || ram_ecc);
	reg  [4:0]  a_sel;
	reg  [7:0]  a_trap_code;

	always @* begin
		a_sel = 5'h00;
		if (a_ram && ram_en && !hit_dram) begin
			if (hit_b4)
				a_sel = 5'h10;
			else if ((bank_idx < 30'h4) && !req_addr[29])
				a_sel = 5'h01 << bank_idx[1:0];
		end
		if (req_write)
			a_trap_code = `TRAP_STORE;
		else if (req_fetch)
			a_trap_code = `TRAP_FETCH;
		else
			a_trap_code = `TRAP_LOAD;
	end

	// ---------------------------------------------------------------
	// per-beat timing
	// ---------------------------------------------------------------
	wire        ready_ctl = is_io_reg ? io_rdy : (is_rom_reg ? rom_rdy :
		(ram_sel_reg[4] && ram_rdy));
	wire        rdy_seen = async_rdy ? (!rdy_s2 && !rdy_s3) : !rdy_s2;
	wire        rdy_ok = !ready_ctl || rdy_seen;
	reg  [4:0]  data_len;

	always @* begin
		if (is_io_reg)
			data_len = {1'b0, io_wait} + (wr_reg ? 5'h1 : 5'h2);
		else if (is_rom_reg)
			data_len = (wr_reg ? {rom_wwait, 1'b0} : {rom_rwait, 1'b0})
				+ (wr_reg ? 5'h1 : 5'h2);
		else
			data_len = {3'h0, (wr_reg ? ram_wwait : ram_rwait)}
				+ (wr_reg ? 5'h1 : 5'h2);
	end

	wire [31:0] word_base = {addr_reg[31:2], 2'h0};
	wire [31:0] beat_addr = burst_reg ? word_base + {29'h0, beat_reg} : addr_reg;
	wire [1:0]  lane_idx = burst_reg ? beat_reg[1:0] : addr_reg[1:0];
	wire        chk_beat = (beat_reg == 3'h4);
	wire        lane_on = chk_beat || !byte_reg || ecc_reg || strb_reg[3 - lane_idx];
	wire [7:0]  wr_byte = chk_beat ? wcheck_reg : wdata_reg[(3 - lane_idx) * 8 +: 8];
	wire [3:0]  lane_strb = rmw_reg ? 4'hF : strb_reg;
	wire        last_tail = wr_reg || tail_reg;

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			data_s1 <= 32'h00000000;
			data_s2 <= 32'h00000000;
			check_s1 <= 8'h00;
			check_s2 <= 8'h00;
			rdy_s1 <= 1'b1;
			rdy_s2 <= 1'b1;
			rdy_s3 <= 1'b1;
		end else begin
			data_s1 <= mem_data_in;
			data_s2 <= data_s1;
			check_s1 <= check_bits_bus_in;
			check_s2 <= check_s1;
			rdy_s1 <= external_ready_n;
			rdy_s2 <= rdy_s1;
			rdy_s3 <= rdy_s2;
		end
	end

	// ---------------------------------------------------------------
	// access sequencer
	// ---------------------------------------------------------------
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= S_IDLE;
			addr_reg <= 32'h00000000;
			wdata_reg <= 32'h00000000;
			wcheck_reg <= 8'h00;
			strb_reg <= 4'h0;
			wr_reg <= 1'b0;
			rmw_reg <= 1'b0;
			is_rom_reg <= 1'b0;
			is_io_reg <= 1'b0;
			ram_sel_reg <= 5'h00;
			byte_reg <= 1'b0;
			burst_reg <= 1'b0;
			ecc_reg <= 1'b0;
			lead_reg <= 1'b0;
			beat_reg <= 3'h0;
			last_beat_reg <= 3'h0;
			cnt_reg <= 5'h00;
			tail_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rcheck_reg <= 8'h00;
			resp_valid <= 1'b0;
			resp_rdata <= 32'h00000000;
			resp_check <= 8'h00;
			resp_trap <= 1'b0;
			resp_trap_code <= 8'h00;
			last_trap_reg <= 8'h00;
		end else begin
			resp_valid <= 1'b0;
			case (state_reg)
			S_IDLE: begin
				if (req_valid) begin
					addr_reg <= req_addr;
					wdata_reg <= req_wdata;
					wcheck_reg <= req_wcheck;
					strb_reg <= req_strb;
					wr_reg <= req_write && !a_rmw;
					rmw_reg <= a_rmw;
					is_rom_reg <= a_rom;
					is_io_reg <= a_io;
					ram_sel_reg <= a_sel;
					byte_reg <= a_byte;
					burst_reg <= a_burst;
					ecc_reg <= a_ecc;
					lead_reg <= a_io || req_write;
					beat_reg <= 3'h0;
					last_beat_reg <= (a_burst ? (a_ecc ? 3'h4 : 3'h3) : 3'h0);
					rdata_reg <= 32'h00000000;
					rcheck_reg <= 8'h00;
					resp_trap_code <= a_trap_code;
					resp_trap <= a_trap;
					if (a_trap) begin
						last_trap_reg <= a_trap_code;
						state_reg <= S_RESP;
					end else if (a_io || (req_write && !a_rmw)) begin
						state_reg <= S_LEAD;
					end else begin
						cnt_reg <= 5'h00;
						state_reg <= S_DATA;
					end
				end
			end
			S_LEAD: begin
				cnt_reg <= 5'h00;
				state_reg <= S_DATA;
			end
			S_DATA: begin
				if (cnt_reg < data_len - 5'h1)
					cnt_reg <= cnt_reg + 5'h1;
				else if (rdy_ok) begin
					tail_reg <= 1'b0;
					state_reg <= S_TAIL;
				end
			end
			S_TAIL: begin
				tail_reg <= 1'b1;
				if (last_tail) begin
					if (!wr_reg) begin
						if (!byte_reg) begin
							rdata_reg <= data_s2;
							rcheck_reg <= ecc_reg ? check_s2 : 8'h00;
						end else if (chk_beat)
							rcheck_reg <= data_s2[31:24];
						else
							rdata_reg[(3 - lane_idx) * 8 +: 8] <= data_s2[31:24];
					end
					if (beat_reg != last_beat_reg) begin
						beat_reg <= beat_reg + 3'h1;
						cnt_reg <= 5'h00;
						state_reg <= lead_reg ? S_LEAD : S_DATA;
					end else if (rmw_reg && !wr_reg) begin
						wdata_reg <= (data_s2 & ~{{8{strb_reg[3]}}, {8{strb_reg[2]}},
							{8{strb_reg[1]}}, {8{strb_reg[0]}}}) | (wdata_reg &
							{{8{strb_reg[3]}}, {8{strb_reg[2]}},
							{8{strb_reg[1]}}, {8{strb_reg[0]}}});
						wr_reg <= 1'b1;
						lead_reg <= 1'b1;
						state_reg <= S_LEAD;
					end else
						state_reg <= S_RESP;
				end
			end
			S_RESP: begin
				resp_valid <= 1'b1;
				resp_rdata <= rdata_reg;
				resp_check <= rcheck_reg;
				state_reg <= S_IDLE;
			end
			default: state_reg <= S_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// memory pins
	// ---------------------------------------------------------------
	wire in_cycle = (state_reg == S_LEAD) || (state_reg == S_DATA)
		|| ((state_reg == S_TAIL) && !tail_reg);
	wire in_data = (state_reg == S_DATA);
	wire wr_data = in_data && wr_reg && lane_on;

	assign req_ready = (state_reg == S_IDLE);
	assign mem_addr = beat_addr[27:0];
	assign mem_data_out = byte_reg ? {wr_byte, 24'h000000} : wdata_reg;
	assign mem_data_oe_n = !(in_cycle && wr_reg);
	assign check_bits_bus_out = wcheck_reg;
	assign check_bits_bus_oe_n = !(in_cycle && wr_reg && !byte_reg && ecc_reg);
	assign read_strobe = in_cycle && !wr_reg;
	assign output_enable_n = !(in_data && !wr_reg);
	assign write_n = !wr_data;
	assign rom_select_n[0] = !(in_cycle && is_rom_reg && !addr_reg[28]);
	assign rom_select_n[1] = !(in_cycle && is_rom_reg && addr_reg[28]);
	assign io_area_select_n = !(in_cycle && is_io_reg);
	assign io_strobe_select_n = !(in_data && is_io_reg);
	assign ram_bank_select_n[4] = !(in_cycle && ram_sel_reg[4]);

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : lane
			assign ram_bank_select_n[g] = !(in_cycle && ram_sel_reg[g]);
			assign ram_output_enable_n[g] = !(in_data && !wr_reg && ram_sel_reg[g]);
			assign ram_lane_write_n[g] = !(wr_data && (ram_sel_reg != 5'h00)
				&& (byte_reg ? (g == 3) : lane_strb[g]));
		end
	endgenerate

	// ---------------------------------------------------------------
	// register read port
	// ---------------------------------------------------------------
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end else if (s_axi_arvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			s_axi_rdata <= 32'h00000000;
			if (s_axi_araddr[31:4] != 28'h0000000)
				s_axi_rresp <= 2'h2;
			else begin
				case (s_axi_araddr[3:0])
				`ROMIO_CFG_OFF: s_axi_rdata <= {14'h0000, romio_cfg_reg};
				`RAM_CFG_OFF:   s_axi_rdata <= {19'h00000, ram_cfg_reg};
				`ECC_CFG_OFF:   s_axi_rdata <= {30'h00000000, ecc_cfg_reg};
				`STATUS_OFF:    s_axi_rdata <= {16'h0000, last_trap_reg, 7'h00,
					(state_reg != S_IDLE)};
				default:        s_axi_rresp <= 2'h2;
				endcase
			end
		end
	end

endmodule

// >>> testbench/smio_chk_sva.sv
// checker for the static memory / io controller pins
// assumes it is bound to the controller top and sees its ports only
`timescale 1ns/1ps
module smio_chk (
	input logic       clk,
	input logic       sys_rst,
	input logic       resp_valid,
	input logic       resp_trap,
	input logic       io_area_select_n,
	input logic       io_strobe_select_n,
	input logic       write_n,
	input logic       mem_data_oe_n,
	input logic       check_bits_bus_oe_n,
	input logic [1:0] rom_select_n,
	input logic [4:0] ram_bank_select_n
);
	// ----
	// io cycle steps
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_lead;
		io_strobe_select_n && !io_area_select_n;
	endsequence
	sequence s_strobe;
		!io_strobe_select_n && !io_area_select_n;
	endsequence
	sequence s_tail;
		io_strobe_select_n && !io_area_select_n ##1 io_area_select_n;
	endsequence
	AST_IO_LEAD_IN: assert property ($fell(io_area_select_n) |-> s_lead ##1 s_strobe)
		else $error("io strobe not one clock after select");
	AST_IO_LEAD_OUT: assert property ($rose(io_strobe_select_n) |-> s_tail)
		else $error("io lead-out cycle missing");
	AST_STROBE_IN_AREA: assert property (!io_strobe_select_n |-> !io_area_select_n)
		else $error("io strobe outside io select");
	AST_IO_NOT_MEM: assert property (!io_area_select_n |-> &{ram_bank_select_n, rom_select_n})
		else $error("memory select during io cycle");
	AST_IO_NO_CHECK: assert property (!io_area_select_n |-> check_bits_bus_oe_n)
		else $error("check bits driven in io area");
	AST_IO_WRITE: assert property ($fell(write_n) && !io_area_select_n |-> s_strobe and !mem_data_oe_n)
		else $error("io write strobe without data");
	AST_BANK_ONEHOT: assert property ($onehot0(~ram_bank_select_n))
		else $error("two ram banks selected");
	AST_TRAP_QUIET: assert property (resp_valid && resp_trap |-> $past(io_area_select_n) && $past(io_area_select_n, 2))
		else $error("trapped access touched io pins");
endmodule

// >>> testbench/smio_mem_model.sv
// byte pattern memory and io device on the controller pins
// assumes data is read combinationally while an output enable is low
`timescale 1ns/1ps
module mem_model (
	input  logic        clk,
	input  logic [27:0] mem_addr,
	input  logic        output_enable_n,
	input  logic [3:0]  ram_output_enable_n,
	input  logic        write_n,
	input  logic [31:0] mem_data_out,
	input  logic        io_strobe_select_n,
	input  logic [7:0]  slow,
	output logic [31:0] mem_data_in,
	output logic [7:0]  check_bits_bus_in,
	output logic        external_ready_n
);
	// ----
	// device
	// ----
	logic [7:0]  last = 8'h00;
	logic [7:0]  cnt = 8'h00;
	logic [7:0]  wr_byte;
	logic [27:0] wr_addr;
	wire         rd = !output_enable_n || !(&ram_output_enable_n);
	wire  [7:0]  pat = mem_addr[7:0] ^ 8'h5A;
	assign mem_data_in = rd ? {4{pat}} : ~{4{last}};
	assign check_bits_bus_in = rd ? pat : ~last;
	assign external_ready_n = cnt < slow;
	always @(posedge clk) begin
		if (rd) last <= pat;
		if (!write_n) begin
			wr_addr <= mem_addr;
			wr_byte <= mem_data_out[31:24];
		end
		cnt <= io_strobe_select_n ? 8'h00 : cnt + 8'h01;
	end
endmodule

// >>> testbench/static_memory_io_controller_bench.sv
// self-checking bench for the static memory / io controller
// assumes the pattern memory model on the pin side
`timescale 1ns/1ps
module static_memory_io_controller_bench;
	// ----
	// signals
	// ----
	logic        clk = '0, sys_rst = 1'b1, s_axi_awvalid = '0, s_axi_wvalid = '0;
	logic        s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0, req_valid = '0;
	logic        req_write = '0, req_fetch = '0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, req_addr = '0;
	logic [31:0] req_wdata = 32'hC3A51E7F;
	logic [3:0]  s_axi_wstrb = 4'hF, req_strb = 4'hF;
	logic [7:0]  req_wcheck = 8'h3C, slow = '0, stb_cnt, wr_cnt;
	logic [4:0]  sel_seen;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire         req_ready, resp_valid, resp_trap, mem_data_oe_n, check_bits_bus_oe_n;
	wire         read_strobe, output_enable_n, write_n, io_area_select_n, io_strobe_select_n;
	wire         external_ready_n, dram_ecc_enable;
	wire [1:0]   s_axi_bresp, s_axi_rresp, rom_select_n;
	wire [31:0]  s_axi_rdata, resp_rdata, mem_data_out, mem_data_in;
	wire [7:0]   resp_check, resp_trap_code, check_bits_bus_out, check_bits_bus_in;
	wire [27:0]  mem_addr;
	wire [4:0]   ram_bank_select_n;
	wire [3:0]   ram_output_enable_n, ram_lane_write_n;
	int          err_count = 0, check_count = 0;
	typedef struct packed {
		logic [31:0] c0, c4, c8, a;
		logic        w, f, cr;
		logic [31:0] rd;
		logic [7:0]  ck, code;
		logic [4:0]  sel;
		logic [7:0]  stb;
	} row_t;
	// io traffic is word sized in 32-bit io mode only
	row_t rows [15] = '{
		'{'0, '0, '0, 32'h20000000, '0, 1'b1, '0, '0, '0, 8'h01, '0, '0},
		'{'0, '0, '0, 32'h20000000, '0, '0, '0, '0, '0, 8'h09, '0, '0},
		'{'0, '0, '0, 32'h20000000, 1'b1, '0, '0, '0, '0, 8'h2B, '0, '0},
		'{32'h2, '0, 32'h3, 32'h20000010, '0, '0, 1'b1, 32'h4A4A4A4A, '0, '0, '0, 8'h02},
		'{32'h2, '0, '0, 32'h30000010, '0, '0, 1'b1, 32'h4A4A4A4A, '0, '0, '0, 8'h02},
		'{32'h7A, '0, '0, 32'h20000010, '0, '0, 1'b1, 32'h4A4A4A4A, '0, '0, '0, 8'h11},
		'{32'h2, '0, '0, 32'h20000004, 1'b1, '0, '0, '0, '0, '0, '0, 8'h01},
		'{32'h1, '0, '0, 32'h20, '0, '0, 1'b1, 32'h7A7B7879, '0, '0, '0, '0},
		'{32'h1, '0, 32'h1, 32'h20, '0, '0, 1'b1, 32'h7A7B7879, 8'h7E, '0, '0, '0},
		'{'0, 32'h1, '0, 32'h40002000, '0, '0, 1'b1, 32'h5A5A5A5A, '0, '0, 5'h02, '0},
		'{'0, 32'h1, '0, 32'h60000000, '0, '0, 1'b1, 32'h5A5A5A5A, '0, '0, 5'h10, '0},
		'{'0, 32'h3D, '0, 32'h60000000, '0, '0, 1'b1, 32'h5A5A5A5A, '0, '0, 5'h10, '0},
		'{'0, 32'h3D, '0, 32'h50000000, '0, '0, 1'b1, 32'h5A5A5A5A, '0, '0, 5'h02, '0},
		'{'0, 32'h1001, '0, 32'h60000000, '0, '0, '0, '0, '0, '0, '0, '0},
		'{'0, 32'h3D, '0, 32'h70000000, '0, '0, '0, '0, '0, '0, '0, '0}
	};
	static_memory_io_controller dut_u (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req_valid, .req_ready,
		.req_addr, .req_write, .req_fetch, .req_strb, .req_wdata, .req_wcheck, .resp_valid,
		.resp_rdata, .resp_check, .resp_trap, .resp_trap_code, .mem_addr, .mem_data_out,
		.mem_data_oe_n, .mem_data_in, .check_bits_bus_out, .check_bits_bus_oe_n,
		.check_bits_bus_in, .read_strobe, .output_enable_n, .write_n, .rom_select_n,
		.io_area_select_n, .io_strobe_select_n, .ram_bank_select_n, .ram_output_enable_n,
		.ram_lane_write_n, .external_ready_n, .dram_ecc_enable);
	mem_model mem_u (.clk, .mem_addr, .output_enable_n, .ram_output_enable_n, .write_n,
		.mem_data_out, .io_strobe_select_n, .slow, .mem_data_in, .check_bits_bus_in,
		.external_ready_n);
	always #5 clk = ~clk;
	// pin activity of the access in flight
	always @(posedge clk)
		if (req_valid && req_ready) {sel_seen, stb_cnt, wr_cnt} <= '0;
		else begin
			sel_seen <= sel_seen | ~ram_bank_select_n;
			stb_cnt <= stb_cnt + {7'h0, !io_strobe_select_n};
			wr_cnt <= wr_cnt + {7'h0, !write_n};
		end
	// ----
	// tasks
	// ----
	task chk(input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
		end
	endtask
	task axw(input logic [31:0] a, d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask
	task axr(input logic [31:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask
	task cfg(input logic [31:0] c0, c4, c8);
		axw(32'h0, c0);
		axw(32'h4, c4);
		axw(32'h8, c8);
	endtask
	task mreq(input logic [31:0] a, input logic w, f, input logic [3:0] s);
		@(posedge clk);
		{req_addr, req_write, req_fetch, req_strb, req_valid} <= {a, w, f, s, 1'b1};
		do @(posedge clk); while (!req_ready);
		req_valid <= 1'b0;
		do @(posedge clk); while (!resp_valid);
	endtask
	task end_sim();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ----
	// sequence
	// ----
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		axr(32'h0);
		chk(s_axi_rdata, 32'h0001FE00);
		axr(32'h10);
		chk(s_axi_rresp, 2'h2);
		axw(32'hC, 32'hFFFFFFFF);
		chk(s_axi_bresp, 2'h2);
		for (int i = 0; i < 15; i++) begin
			cfg(rows[i].c0, rows[i].c4, rows[i].c8);
			mreq(rows[i].a, rows[i].w, rows[i].f, 4'hF);
			chk(resp_trap, rows[i].code != 8'h00);
			if (rows[i].code != 8'h00) chk(resp_trap_code, rows[i].code);
			if (rows[i].cr) chk(resp_rdata, rows[i].rd);
			if (rows[i].cr) chk(resp_check, rows[i].ck);
			chk(dram_ecc_enable, rows[i].c8[1]);
			chk(sel_seen, rows[i].sel);
			chk(stb_cnt, rows[i].stb);
		end
		cfg(32'h1, '0, '0);
		mreq(32'h40, 1'b1, 1'b0, 4'h4);
		chk(wr_cnt, 8'h01);
		chk(mem_u.wr_addr, 28'h0000041);
		chk(mem_u.wr_byte, req_wdata[23:16]);
		cfg(32'h1, '0, 32'h1);
		// full-word store to byte-wide rom with ecc writes four bytes, then the check byte
		mreq(32'h40, 1'b1, 1'b0, 4'hF);
		chk(wr_cnt, 8'h05);
		chk(mem_u.wr_addr, 28'h0000044);
		for (int k = 0; k < 2; k++) begin
			cfg(32'h82 | (k << 8), '0, '0);
			slow <= 8'h06;
			mreq(32'h20000010, 1'b0, 1'b0, 4'hF);
			chk(stb_cnt >= 8'h07, 1'b1);
			chk(resp_rdata, 32'h4A4A4A4A);
		end
		cfg('0, 32'h401, '0);
		mreq(32'h40000000, 1'b1, 1'b0, 4'h4);
		chk(wr_cnt, 8'h01);
		chk(mem_u.wr_byte, 8'h5A);
		chk(sel_seen, 5'h01);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		axr(32'h0);
		chk(s_axi_rdata, 32'h0001FE00);
		end_sim();
	end
	initial begin
		#300000;
		err_count++;
		end_sim();
	end
endmodule
bind static_memory_io_controller smio_chk chk_u (.clk(clk), .sys_rst(sys_rst),
	.resp_valid(resp_valid), .resp_trap(resp_trap), .io_area_select_n(io_area_select_n),
	.io_strobe_select_n(io_strobe_select_n), .write_n(write_n), .mem_data_oe_n(mem_data_oe_n),
	.check_bits_bus_oe_n(check_bits_bus_oe_n), .rom_select_n(rom_select_n),
	.ram_bank_select_n(ram_bank_select_n));
